// file: rtl/pacc_consts.svh
// Register offsets, field positions, reset values and timing counts of the pulse accumulator.
`ifndef PACC_CONSTS_SVH
`define PACC_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define PACC_IDX_MASK2 14'h1024
`define PACC_IDX_FLAG2 14'h1025
`define PACC_IDX_CTRL 14'h1026
`define PACC_IDX_COUNT 14'h1027

// Bit positions in the second mask and second flag registers.
`define PACC_BIT_MAIN_OVF 7
`define PACC_BIT_PERIODIC 6
`define PACC_BIT_ACC_OVF 5
`define PACC_BIT_ACC_EDGE 4

// Bit positions in the accumulator control register.
`define PACC_BIT_ENABLE 6
`define PACC_BIT_MODE 5
`define PACC_BIT_EDGE 4
`define PACC_BIT_CCS 2

// Reset values.
`define PACC_RST_BYTE 8'h00
`define PACC_RST_FLAGS 4'h0
`define PACC_RST_PRESCALE 2'h0

// Timing counts in clock cycles, the periodic counter width and counter maxima.
`define PACC_PR_WINDOW 7'h40
`define PACC_GATE_LAST 6'h3F
`define PACC_RTI_BASE 8192
`define PACC_RTI_W 17
`define PACC_MAIN_MAX 16'hFFFF
`define PACC_COUNT_MAX 8'hFF

`endif

// file: rtl/pacc_pkg.sv
// Types shared by the pulse accumulator design.
package pacc_pkg;

  typedef logic [31:0] pacc_word_t;

  // Every flip-flop of the block.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic pin_prev;
    logic [3:0] irq_en;
    logic [1:0] prescale;
    logic pr_written;
    logic [6:0] boot_cnt;
    logic [3:0] flags;
    logic acc_en;
    logic acc_mode;
    logic acc_edge;
    logic ccs;
    logic [1:0] rate;
    logic [7:0] count;
    logic [5:0] gate_div;
    logic [3:0] pre;
    logic [15:0] main;
    logic [16:0] rti_cnt;
    logic ack;
    logic [7:0] dat;
    logic irq;
  } pacc_state_t;

endpackage

// file: rtl/pacc_top.sv
// Pulse accumulator, periodic interrupt timer and shared mask and flag registers.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
`include "pacc_consts.svh"

module pacc_top #(
  parameter int RTI_BASE_CYCLES = `PACC_RTI_BASE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire pacc_pkg::pacc_word_t wb_dat_i,
  output pacc_pkg::pacc_word_t wb_dat_o,
  output logic wb_ack_o,
  input wire logic accum_input_pin_i,
  output logic irq_o,
  output logic fourth_capture_en_o,
  output logic fifth_compare_en_o
);
  import pacc_pkg::*;

  pacc_state_t s_q;
  pacc_state_t s_d;

  // Last count value of the current periodic interval.
  function automatic logic [16:0] rti_last(input logic [1:0] rate);
    rti_last = (17'(RTI_BASE_CYCLES) << rate) - 17'h0_001;
  endfunction

  // Prescaler divide mask for 1, 4, 8 and 16.
  function automatic logic [3:0] pre_mask(input logic [1:0] sel);
    unique case (sel)
      2'h0: pre_mask = 4'h0;
      2'h1: pre_mask = 4'h3;
      2'h2: pre_mask = 4'h7;
      2'h3: pre_mask = 4'hF;
    endcase
  endfunction

  // Bus decode; a write or clear takes effect at the edge where ack is high.
  logic bus_req;
  logic bus_wr;
  logic [13:0] bus_idx;
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_idx = wb_adr_i[15:2];
  assign bus_wr = bus_req && wb_we_i && s_q.ack && wb_sel_i[0];

  logic wr_mask;
  logic wr_flag;
  logic wr_ctrl;
  logic wr_count;
  assign wr_mask = bus_wr && (bus_idx == `PACC_IDX_MASK2);
  assign wr_flag = bus_wr && (bus_idx == `PACC_IDX_FLAG2);
  assign wr_ctrl = bus_wr && (bus_idx == `PACC_IDX_CTRL);
  assign wr_count = bus_wr && (bus_idx == `PACC_IDX_COUNT);

  // Pin edges are taken between the second sync stage and its delayed copy.
  logic pin_rise;
  logic pin_fall;
  logic edge_ev;
  logic pin_active;
  assign pin_rise = s_q.sync2 && !s_q.pin_prev;
  assign pin_fall = !s_q.sync2 && s_q.pin_prev;
  // The selected edge is the counted edge in event mode and the trailing edge in gated mode.
  assign edge_ev = s_q.acc_en && (s_q.acc_edge ? pin_rise : pin_fall);
  assign pin_active = (s_q.sync2 != s_q.acc_edge);

  // Increment sources for the accumulator.
  logic gate_tick;
  logic acc_inc;
  logic ovf_ev;
  assign gate_tick = (s_q.gate_div == `PACC_GATE_LAST);
  assign acc_inc = s_q.acc_en && (s_q.acc_mode ? (gate_tick && pin_active) : edge_ev);
  // A bus write of the count wins over an increment in the same cycle.
  assign ovf_ev = acc_inc && !wr_count && (s_q.count == `PACC_COUNT_MAX);

  // Main counter and periodic timer events.
  logic main_tick;
  logic tof_ev;
  logic rti_ev;
  assign main_tick = ((s_q.pre & pre_mask(s_q.prescale)) == pre_mask(s_q.prescale));
  assign tof_ev = main_tick && (s_q.main == `PACC_MAIN_MAX);
  assign rti_ev = (s_q.rti_cnt >= rti_last(s_q.rate));

  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  assign flag_set = {tof_ev, rti_ev, ovf_ev, edge_ev};
  assign flag_clr = wr_flag ? wb_dat_i[7:4] : 4'h0;

  // Next state of the whole block.
  always_comb begin
    s_d = s_q;
    // The first sync stage feeds only the second.
    s_d.sync1 = accum_input_pin_i;
    s_d.sync2 = s_q.sync1;
    s_d.pin_prev = s_q.sync2;

    // Free-running dividers; none of them is stopped by software.
    s_d.gate_div = s_q.gate_div + 6'h01;
    s_d.pre = s_q.pre + 4'h1;
    if (main_tick) begin
      s_d.main = s_q.main + 16'h0001;
    end
    if (rti_ev) begin
      s_d.rti_cnt = '0;
    end else begin
      s_d.rti_cnt = s_q.rti_cnt + 17'h0_0001;
    end
    if (s_q.boot_cnt != `PACC_PR_WINDOW) begin
      s_d.boot_cnt = s_q.boot_cnt + 7'h01;
    end

    // Flags: a set in the same cycle as its clear wins, a zero write keeps the flag.
    s_d.flags = (s_q.flags & ~flag_clr) | flag_set;

    // Accumulator count; software writes it at any time.
    if (wr_count) begin
      s_d.count = wb_dat_i[7:0];
    end else if (acc_inc) begin
      s_d.count = s_q.count + 8'h01;
    end

    if (wr_mask) begin
      s_d.irq_en = wb_dat_i[7:4];
      // The prescaler takes one write, and only inside the window after reset.
      if (!s_q.pr_written && (s_q.boot_cnt != `PACC_PR_WINDOW)) begin
        s_d.prescale = wb_dat_i[1:0];
        s_d.pr_written = 1'b1;
      end
    end
    if (wr_ctrl) begin
      s_d.acc_en = wb_dat_i[`PACC_BIT_ENABLE];
      s_d.acc_mode = wb_dat_i[`PACC_BIT_MODE];
      s_d.acc_edge = wb_dat_i[`PACC_BIT_EDGE];
      s_d.ccs = wb_dat_i[`PACC_BIT_CCS];
      s_d.rate = wb_dat_i[1:0];
    end

    // Wishbone classic: ack one cycle after the request, dropped the cycle after.
    s_d.ack = bus_req && !s_q.ack;
    s_d.dat = 8'h00;
    if (bus_req && !s_q.ack) begin
      unique case (bus_idx)
        `PACC_IDX_MASK2: s_d.dat = {s_q.irq_en, 2'b00, s_q.prescale};
        `PACC_IDX_FLAG2: s_d.dat = {s_q.flags, 4'h0};
        `PACC_IDX_CTRL: s_d.dat = {1'b0, s_q.acc_en, s_q.acc_mode, s_q.acc_edge,
                                   1'b0, s_q.ccs, s_q.rate};
        `PACC_IDX_COUNT: s_d.dat = s_q.count;
        default: s_d.dat = 8'h00;
      endcase
    end

    // Pending interrupt is registered from the next flags and enables.
    s_d.irq = |(s_d.flags & s_d.irq_en);
  end

  // Reset value; the accumulator count survives reset.
  pacc_state_t s_rst;
  always_comb begin
    s_rst = '0;
    s_rst.flags = `PACC_RST_FLAGS;
    s_rst.prescale = `PACC_RST_PRESCALE;
    s_rst.dat = `PACC_RST_BYTE;
    s_rst.count = s_q.count;
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= s_rst;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {24'h00_0000, s_q.dat};
  assign irq_o = s_q.irq;
  // The shared pin goes to one function only.
  assign fourth_capture_en_o = s_q.ccs;
  assign fifth_compare_en_o = !s_q.ccs;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Enabled main overflow flag must raise the interrupt.
  main_ovf_irq_a: assert property (
    (s_q.flags[3] && s_q.irq_en[3]) |-> irq_o)
    else $error("main overflow flag enabled but no interrupt");

  // Enabled periodic flag must raise the interrupt.
  periodic_irq_a: assert property (
    (s_q.flags[2] && s_q.irq_en[2]) |-> irq_o)
    else $error("periodic flag enabled but no interrupt");

  // Interrupt is exactly the OR of enabled flags.
  irq_gate_a: assert property (
    irq_o == |(s_q.flags & s_q.irq_en))
    else $error("interrupt does not match enabled flags");

  // A one written with no new event clears the flag.
  flag_clear_a: assert property (
    (wr_flag && wb_dat_i[7] && !tof_ev) |=> !s_q.flags[3])
    else $error("main overflow flag not cleared by one");

  // A zero written in bit 6 leaves the periodic flag alone.
  flag_hold_a: assert property (
    (wr_flag && !wb_dat_i[6] && !rti_ev) |=> (s_q.flags[2] == $past(s_q.flags[2])))
    else $error("periodic flag changed by zero write");

  // Main counter wrap sets its flag next cycle.
  main_wrap_a: assert property (
    tof_ev |=> (s_q.main == 16'h0000) && s_q.flags[3])
    else $error("main counter wrap did not set flag");

  // Periodic timeout restarts the interval and sets the flag.
  periodic_restart_a: assert property (
    (rti_ev && s_q.rate == 2'h0) |=> (s_q.rti_cnt == 17'h0_0000) && s_q.flags[2]
      ##1 (s_q.rti_cnt == 17'h0_0001))
    else $error("periodic interval not restarted from timeout");

  // Flag register reads show zero in the low nibble.
  flag_low_zero_a: assert property (
    (s_q.ack && $past(bus_idx) == `PACC_IDX_FLAG2) |-> (s_q.dat[3:0] == 4'h0))
    else $error("flag register low bits not zero");

  // Control register bits 7 and 3 read zero.
  ctrl_zero_a: assert property (
    (s_q.ack && $past(bus_idx) == `PACC_IDX_CTRL) |-> !s_q.dat[7] && !s_q.dat[3])
    else $error("control register reserved bits not zero");

  // Count rollover sets the overflow flag and wraps to zero.
  count_roll_a: assert property (
    ovf_ev |=> (s_q.count == 8'h00) && s_q.flags[1])
    else $error("accumulator rollover did not set flag");

  // Inhibited gated mode keeps the count.
  gate_inhibit_a: assert property (
    (s_q.acc_mode && !pin_active && !wr_count) |=> (s_q.count == $past(s_q.count)))
    else $error("count moved while gate inhibited");

  // Disabled accumulator never counts.
  acc_off_a: assert property (
    (!s_q.acc_en && !wr_count) |=> $stable(s_q.count))
    else $error("count moved while accumulator disabled");

  // Prescaler is frozen once written.
  prescale_lock_a: assert property (
    s_q.pr_written |=> $stable(s_q.prescale))
    else $error("prescaler changed after its single write");

  // Capture and compare are never enabled together.
  ccs_excl_a: assert property (
    fourth_capture_en_o != fifth_compare_en_o)
    else $error("capture and compare enabled together");

  // The checks below cover the remaining flag, count and bus behaviour.
  // Each clear and step check names the event that must not be present for the claim to hold.
  // A set always beats a clear in the same cycle, so every clear check excludes its set.
  // The count step check leaves out cycles with a bus write, because that write has priority.

  // Enabled accumulator overflow flag must raise the interrupt.
  acc_ovf_irq_a: assert property (
    (s_q.flags[1] && s_q.irq_en[1]) |-> irq_o)
    else $error("accumulator overflow flag enabled but no interrupt");

  // Enabled edge flag must raise the interrupt.
  edge_irq_a: assert property (
    (s_q.flags[0] && s_q.irq_en[0]) |-> irq_o)
    else $error("edge flag enabled but no interrupt");

  // With no enabled flag the interrupt stays low.
  no_irq_a: assert property (
    ((s_q.flags & s_q.irq_en) == 4'h0) |-> !irq_o)
    else $error("interrupt raised with no enabled flag");

  // A periodic timeout sets its flag.
  periodic_set_a: assert property (
    rti_ev |=> s_q.flags[2])
    else $error("periodic timeout did not set flag");

  // A selected pin edge sets the edge flag.
  edge_set_a: assert property (
    edge_ev |=> s_q.flags[0])
    else $error("selected edge did not set edge flag");

  // A one in bit 4 clears the edge flag.
  edge_clear_a: assert property (
    (wr_flag && wb_dat_i[4] && !edge_ev) |=> !s_q.flags[0])
    else $error("edge flag not cleared by one");

  // A one in bit 5 clears the overflow flag.
  ovf_clear_a: assert property (
    (wr_flag && wb_dat_i[5] && !ovf_ev) |=> !s_q.flags[1])
    else $error("overflow flag not cleared by one");

  // A one in bit 6 clears the periodic flag.
  periodic_clear_a: assert property (
    (wr_flag && wb_dat_i[6] && !rti_ev) |=> !s_q.flags[2])
    else $error("periodic flag not cleared by one");

  // A count write lands whatever the counting sources do.
  count_write_a: assert property (
    wr_count |=> (s_q.count == $past(wb_dat_i[7:0])))
    else $error("count write did not land");

  // Every increment moves the count by exactly one, wrapping at the top.
  incr_step_a: assert property (
    (acc_inc && !wr_count) |=> (s_q.count == 8'($past(s_q.count) + 8'h01)))
    else $error("count did not step by one");

  // Ack is a single-cycle pulse per request.
  ack_pulse_a: assert property (
    s_q.ack |=> !s_q.ack)
    else $error("ack held longer than one cycle");

  // A new request is answered in the next cycle.
  ack_answer_a: assert property (
    (bus_req && !s_q.ack) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  // Read data is zero whenever ack is low.
  read_idle_zero_a: assert property (
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
    else $error("read data not zero outside ack");

  // A periodic count past the new last value restarts at once after a rate change.
  rti_bound_a: assert property (
    (s_q.rti_cnt > rti_last(s_q.rate)) |=> (s_q.rti_cnt == 17'h0_0000))
    else $error("periodic counter ran past its interval");

  // The main counter steps by one on each prescaled tick.
  main_step_a: assert property (
    (main_tick && !tof_ev) |=> (s_q.main == 16'($past(s_q.main) + 16'h0001)))
    else $error("main counter did not step by one");

  // A prescaler write after the window is ignored.
  prescale_window_a: assert property (
    (wr_mask && (s_q.boot_cnt == `PACC_PR_WINDOW)) |=> $stable(s_q.prescale))
    else $error("prescaler changed after its window");

endmodule

// file: verification/pacc_pin_model.sv
// Model of the external event source that drives the accumulator input pin.
`timescale 1ns/100ps

module pacc_pin_model (
  input wire logic clk_i,
  input wire logic idle_i,
  input wire logic start_i,
  input wire logic [3:0] num_i,
  input wire logic [3:0] half_i,
  output logic pin_o,
  output logic busy_o
);
  logic act_q = 1'b0;
  logic [4:0] left_q = 5'h00;
  logic [3:0] t_q = 4'h0;
  logic [3:0] hf;

  // A source never toggles faster than every two clocks, so short halves are stretched.
  assign hf = (half_i < 4'h2) ? 4'h2 : half_i;
  assign pin_o = idle_i ^ act_q;
  assign busy_o = (left_q != 5'h00);

  // Each pulse is two level changes away from and back to the idle level.
  always @(posedge clk_i) begin
    if (start_i && !busy_o) begin
      left_q <= {num_i, 1'b0};
      t_q <= hf;
    end else if (busy_o) begin
      if (t_q > 4'h1) begin
        t_q <= t_q - 4'h1;
      end else begin
        act_q <= ~act_q;
        left_q <= left_q - 5'h01;
        t_q <= hf;
      end
    end
  end
endmodule

// file: verification/tb.sv
// Self-checking testbench of the pulse accumulator block.
`timescale 1ns/100ps
`include "pacc_consts.svh"

module tb;
  import pacc_pkg::*;
  localparam logic [13:0] i_mk = `PACC_IDX_MASK2;
  localparam logic [13:0] i_fl = `PACC_IDX_FLAG2;
  localparam logic [13:0] i_ct = `PACC_IDX_CTRL;
  localparam logic [13:0] i_cn = `PACC_IDX_COUNT;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [15:0] adr = 16'h0000;
  pacc_word_t wdat = 32'h0000_0000;
  pacc_word_t rdat;
  logic ack, pin, irq, f4, f5, busy;
  logic idle = 1'b0;
  logic start = 1'b0;
  logic [3:0] num = 4'h0;
  logic [3:0] half = 4'h0;
  logic [7:0] rdv;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc_n = 0;
  int t0;

  // Free-running clock and a cycle counter for interval checks.
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc_n <= cyc_n + 1;

  pacc_top #(.RTI_BASE_CYCLES(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .accum_input_pin_i(pin), .irq_o(irq),
    .fourth_capture_en_o(f4), .fifth_compare_en_o(f5));

  pacc_pin_model u_pin (.clk_i(clk_i), .idle_i(idle), .start_i(start), .num_i(num),
    .half_i(half), .pin_o(pin), .busy_o(busy));

  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // One classic cycle; the request is held until ack is sampled high.
  task automatic bus(input logic w, input logic [13:0] i, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdv = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk1(1'b1, 1'b0);
  endtask

  task automatic wr(input logic [13:0] i, input logic [7:0] d);
    bus(1'b1, i, d);
  endtask

  task automatic rdc(input logic [13:0] i, input logic [7:0] m, input logic [7:0] e);
    bus(1'b0, i, 8'h00);
    chk8(e, rdv & m);
  endtask

  // The interrupt output is registered, so let its update land first.
  task automatic chkirq(input logic e);
    repeat (2) @(posedge clk_i);
    chk1(e, irq);
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    @(posedge clk_i);
    do begin
      @(posedge clk_i);
      n++;
    end while (irq !== 1'b1 && n < lim);
  endtask

  task automatic lvl(input logic v);
    @(posedge clk_i) idle <= v;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic pulses(input logic [3:0] n, input logic [3:0] h);
    @(posedge clk_i) start <= 1'b1;
    num <= n;
    half <= h;
    @(posedge clk_i) start <= 1'b0;
    repeat (200) @(posedge clk_i) if (!busy) break;
    repeat (8) @(posedge clk_i);
  endtask

  task automatic reset_dut;
    @(posedge clk_i) rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic t_regs;
    wr(i_mk, 8'h00);
    wr(i_mk, 8'h03);
    rdc(i_mk, 8'hFF, 8'h00);
    rdc(i_fl, 8'h0F, 8'h00);
    rdc(14'h0000, 8'hFF, 8'h00);
  endtask

  task automatic t_ctrl;
    wr(i_ct, 8'hFF);
    rdc(i_ct, 8'hFF, 8'h77);
    chk1(1'b1, f4);
    chk1(1'b0, f5);
    wr(i_ct, 8'h00);
    chkirq(1'b0);
    chk1(1'b1, f5);
  endtask

  task automatic t_keep;
    wr(i_cn, 8'h5A);
    reset_dut();
    rdc(i_cn, 8'hFF, 8'h5A);
    rdc(i_ct, 8'hFF, 8'h00);
  endtask

  task automatic t_event;
    wr(i_ct, 8'h50);
    wr(i_cn, 8'hFE);
    wr(i_fl, 8'hF0);
    lvl(1'b1);
    rdc(i_cn, 8'hFF, 8'hFF);
    lvl(1'b0);
    rdc(i_cn, 8'hFF, 8'hFF);
    pulses(4'h1, 4'h0);
    rdc(i_cn, 8'hFF, 8'h00);
    rdc(i_fl, 8'h30, 8'h30);
    wr(i_fl, 8'h00);
    rdc(i_fl, 8'h30, 8'h30);
    wr(i_mk, 8'h20);
    chkirq(1'b1);
    wr(i_fl, 8'h20);
    chkirq(1'b0);
    rdc(i_fl, 8'h30, 8'h10);
    wr(i_mk, 8'h10);
    chkirq(1'b1);
    wr(i_fl, 8'h10);
    chkirq(1'b0);
    wr(i_ct, 8'h40);
    lvl(1'b1);
    rdc(i_cn, 8'hFF, 8'h00);
    lvl(1'b0);
    rdc(i_cn, 8'hFF, 8'h01);
  endtask

  task automatic t_off;
    wr(i_ct, 8'h10);
    wr(i_fl, 8'hF0);
    pulses(4'h3, 4'h5);
    rdc(i_cn, 8'hFF, 8'h01);
    rdc(i_fl, 8'h10, 8'h00);
  endtask

  task automatic t_gated;
    wr(i_ct, 8'h70);
    lvl(1'b1);
    wr(i_cn, 8'h00);
    repeat (200) @(posedge clk_i);
    rdc(i_cn, 8'hFF, 8'h00);
    lvl(1'b0);
    wr(i_cn, 8'h00);
    repeat (256) @(posedge clk_i);
    bus(1'b0, i_cn, 8'h00);
    chk1(1'b1, rdv >= 8'h03 && rdv <= 8'h05);
  endtask

  // Intervals are measured between two timeouts with a late clear between them.
  task automatic t_rti;
    wr(i_mk, 8'h40);
    for (int r = 0; r < 4; r++) begin
      wr(i_ct, 8'(r));
      wr(i_fl, 8'h40);
      wait_irq(300);
      wr(i_fl, 8'h40);
      wait_irq(300);
      t0 = cyc_n;
      wr(i_fl, 8'h40);
      wait_irq(300);
      chk8(8'(16 << r), 8'(cyc_n - t0));
    end
    wr(i_mk, 8'h00);
    chkirq(1'b0);
  endtask

  task automatic t_main;
    wr(i_fl, 8'hF0);
    wr(i_mk, 8'h80);
    wait_irq(70000);
    rdc(i_fl, 8'h80, 8'h80);
    wr(i_fl, 8'h80);
    chkirq(1'b0);
  endtask

  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    reset_dut();
    t_regs();
    t_ctrl();
    t_keep();
    t_event();
    t_off();
    t_gated();
    t_rti();
    t_main();
    close_out();
  end

  // Watchdog sized above the main counter wrap that the last scenario waits for.
  initial begin
    repeat (95000) @(posedge clk_i);
    bad_count++;
    close_out();
  end
endmodule
